/* common/pfe_pkg.sv */
// Package of constants and carrier types for the port fault and emulation configuration block.
`default_nettype none
package pfe_pkg;
	// Register offsets on the documented register port.
	localparam logic [7:0] PFE_OFS_FAULT = 8'h1C; // Fault retry configuration.
	localparam logic [7:0] PFE_OFS_THR = 8'h1E; // Charge detect threshold.
	localparam logic [7:0] PFE_OFS_WAIT = 8'h1F; // Thermal hold and recharge wait timing.
	localparam logic [7:0] PFE_OFS_BC = 8'h20; // BC profile enable.
	localparam logic [7:0] PFE_OFS_LEG = 8'h21; // Legacy profile enable.
	// Reset values.
	localparam logic [7:0] PFE_RST_FAULT = 8'h2A;
	localparam logic [7:0] PFE_RST_THR = 8'h0F;
	localparam logic [7:0] PFE_RST_WAIT = 8'h03;
	localparam logic [7:0] PFE_RST_BC = 8'h16;
	localparam logic [7:0] PFE_RST_LEG = 8'h00;
	// Implemented bit masks; unimplemented bits read as zero.
	localparam logic [7:0] PFE_MSK_FAULT = 8'h7F;
	localparam logic [7:0] PFE_MSK_THR = 8'h0F;
	localparam logic [7:0] PFE_MSK_WAIT = 8'h1F;
	localparam logic [7:0] PFE_MSK_BC = 8'h17;
	localparam logic [7:0] PFE_MSK_LEG = 8'h7F;
	// Field positions.
	localparam int PFE_RETRY_LSB = 4; // Retry delay select, bits 6 to 4.
	localparam int PFE_TPER_LSB = 2; // Test period select, bits 3 to 2.
	localparam int PFE_VTST_LSB = 0; // Test voltage select, bits 1 to 0.
	localparam int PFE_THOLD_LSB = 3; // Thermal hold select, bits 4 to 3.
	localparam int PFE_RWAIT_LSB = 0; // Recharge wait select, bits 2 to 0.
	localparam int PFE_DCP_OFF_BIT = 4; // DCP profile off bit.
	// Timing figures in milliseconds and millivolts.
	localparam logic [11:0] PFE_RETRY_BASE_MS = 12'h00F; // 15 ms at code 0.
	localparam logic [11:0] PFE_TPER_BASE_MS = 12'h00A; // 10 ms at code 0.
	localparam logic [11:0] PFE_STEP5_MS = 12'h005; // 5 ms step.
	localparam logic [11:0] PFE_THOLD_BASE_MS = 12'h0C8; // 200 ms, doubled per code.
	localparam logic [11:0] PFE_RWAIT_STEP_MS = 12'h0C8; // 200 ms step.
	localparam logic [11:0] PFE_RWAIT_TOP_MS = 12'h7D0; // 2000 ms for the top code.
	localparam logic [12:0] PFE_VTST_STEP_MV = 13'h00FA; // 250 mV step.
	// Threshold weight: 11.72 mA is 1172 units of 10 uA.
	localparam logic [18:0] PFE_CHG_LSB_10UA = 19'h00494;
	// Clock rate and the per-millisecond cycle count derived from it.
	localparam int PFE_CLK_MHZ = 100;
	localparam int PFE_CYC_PER_MS = PFE_CLK_MHZ * 1000;
	localparam int PFE_PRE_W = 17; // Prescaler width, holds one millisecond of cycles.

	// Register port request.
	typedef struct packed
	{
		logic wr; // Write strobe.
		logic rd; // Read strobe.
		logic [7:0] addr; // Register offset.
		logic [7:0] wdata; // Write data.
	} pfe_req_t;

	// Fault recovery states.
	typedef enum logic [1:0]
	{
		PFE_ST_RUN = 2'b00,
		PFE_ST_ERROR = 2'b01,
		PFE_ST_CHECK = 2'b10,
		PFE_ST_TEST = 2'b11
	} pfe_state_t;
endpackage
`default_nettype wire

/* core/pfe_ms_timer.sv */
// Retriggerable millisecond timer with a one-cycle expiry pulse.
`default_nettype none
module pfe_ms_timer
#(
	parameter int CYCLES_PER_MS = pfe_pkg::PFE_CYC_PER_MS
)
(
	input wire logic mclk, // System clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic start, // Restart with a new length.
	input wire logic [11:0] load_ms, // Length in milliseconds.
	output logic busy, // Timer running.
	output logic done // One-cycle expiry pulse.
);
	import pfe_pkg::*;
	logic [PFE_PRE_W-1:0] pre_r, pre_nxt; // Cycle prescaler.
	logic [11:0] ms_r, ms_nxt; // Milliseconds left.
	logic busy_r, busy_nxt, done_r, done_nxt;

	// A restart wins over expiry so a retrigger always gives a full length.
	always_comb
	begin
		pre_nxt = pre_r;
		ms_nxt = ms_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (start)
		begin
			pre_nxt = '0;
			ms_nxt = load_ms;
			busy_nxt = (load_ms != 12'h000);
		end
		else if (busy_r)
		begin
			if (pre_r == PFE_PRE_W'(CYCLES_PER_MS - 1))
			begin
				pre_nxt = '0;
				ms_nxt = ms_r - 12'h001;
				if (ms_r == 12'h001)
				begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
			end
			else
				pre_nxt = pre_r + PFE_PRE_W'(1);
		end
	end

	// Timer state registers.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pre_r <= '0;
			ms_r <= 12'h000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			ms_r <= ms_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
endmodule
`default_nettype wire

/* core/pfe_port_cfg.sv */
// Configuration registers and fault, thermal, recharge and emulation timing of a USB port power controller.
`default_nettype none
module pfe_port_cfg
#(
	parameter int CYCLES_PER_MS = pfe_pkg::PFE_CYC_PER_MS // Shorten for simulation.
)
(
	input wire logic mclk, // System clock, 100 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire pfe_pkg::pfe_req_t reg_req, // Register port request.
	output logic [7:0] reg_rdata_r, // Read data, valid the cycle after a read.
	input wire logic sleep_entry, // Pulse on entering Sleep.
	input wire logic fault_detect, // Error condition seen.
	input wire logic latch_on_error, // Latch errors instead of retrying.
	input wire logic err_clear, // Software clears the error flag.
	input wire logic checks_ok, // Over-temperature and back-drive checks done.
	input wire logic [12:0] vbus_mv, // Port bus voltage in mV.
	input wire logic [18:0] ibus_10ua, // Port bus current in 10 uA units.
	input wire logic over_treg, // Temperature above regulation threshold.
	input wire logic bypass_reactivated, // Pulse: bus discharged, bypass back on.
	input wire logic mode_select_a, // Mode input a.
	input wire logic mode_select_b, // Mode input b.
	input wire logic emulation_on, // Emulation enable.
	output logic error_flag_r, // Port in Error, Check or Test state.
	output logic test_current_r, // Current limit lowered to test current.
	output logic switch_on_r, // Port power switch on.
	output logic short_found_r, // One-cycle pulse on a detected short.
	output logic emulation_ok_r, // Charger emulation successful.
	output logic current_limit_value_change_ok_r, // Current limit may change.
	output logic attach_ok_r, // Attach detection allowed.
	output logic dcp_profile_en_r, // DCP profile in the dedicated cycle.
	output logic [6:0] legacy_profile_en_r // Legacy profiles 1 to 7 enabled.
);
	import pfe_pkg::*;

	// Retry delay, linear over all codes including 100.
	function automatic logic [11:0] retry_ms(input logic [2:0] c);
		retry_ms = PFE_RETRY_BASE_MS + PFE_STEP5_MS * {9'h000, c};
	endfunction

	// Test period length.
	function automatic logic [11:0] test_ms(input logic [1:0] c);
		test_ms = PFE_TPER_BASE_MS + PFE_STEP5_MS * {10'h000, c};
	endfunction

	// Short-circuit decision voltage.
	function automatic logic [12:0] vtest_mv(input logic [1:0] c);
		vtest_mv = PFE_VTST_STEP_MV * ({11'h000, c} + 13'h0001);
	endfunction

	// DCP mode decode of the mode inputs; assumed both mode inputs high with emulation on.
	function automatic logic dcp_mode(input logic a, input logic b, input logic en);
		dcp_mode = a & b & en;
	endfunction

	logic [7:0] fault_r, thr_r, wait_r, bc_r, leg_r; // Register storage.
	logic [7:0] fault_nxt, thr_nxt, wait_nxt, bc_nxt, leg_nxt, rdata_nxt;
	logic [2:0] retry_sel;
	logic [1:0] tper_sel, vtst_sel, thold_sel;
	logic [2:0] rwait_sel;
	logic [3:0] charge_detect_level;
	assign retry_sel = fault_r[PFE_RETRY_LSB +: 3];
	assign tper_sel = fault_r[PFE_TPER_LSB +: 2];
	assign vtst_sel = fault_r[PFE_VTST_LSB +: 2];
	assign thold_sel = wait_r[PFE_THOLD_LSB +: 2];
	assign rwait_sel = wait_r[PFE_RWAIT_LSB +: 3];
	assign charge_detect_level = thr_r[3:0];

	// Register writes; a Sleep entry forces only the threshold back to default.
	always_comb
	begin
		fault_nxt = fault_r;
		thr_nxt = thr_r;
		wait_nxt = wait_r;
		bc_nxt = bc_r;
		leg_nxt = leg_r;
		rdata_nxt = reg_rdata_r;
		if (reg_req.wr)
		begin
			unique case (reg_req.addr)
				PFE_OFS_FAULT: fault_nxt = reg_req.wdata & PFE_MSK_FAULT;
				PFE_OFS_THR: thr_nxt = reg_req.wdata & PFE_MSK_THR;
				PFE_OFS_WAIT: wait_nxt = reg_req.wdata & PFE_MSK_WAIT;
				PFE_OFS_BC: bc_nxt = reg_req.wdata & PFE_MSK_BC;
				PFE_OFS_LEG: leg_nxt = reg_req.wdata & PFE_MSK_LEG;
				default: ; // Unmapped writes are dropped.
			endcase
		end
		if (sleep_entry)
			thr_nxt = PFE_RST_THR;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				PFE_OFS_FAULT: rdata_nxt = fault_r;
				PFE_OFS_THR: rdata_nxt = thr_r;
				PFE_OFS_WAIT: rdata_nxt = wait_r;
				PFE_OFS_BC: rdata_nxt = bc_r;
				PFE_OFS_LEG: rdata_nxt = leg_r;
				default: rdata_nxt = 8'h00; // Unmapped reads give zero.
			endcase
		end
	end

	// Register storage flops.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fault_r <= PFE_RST_FAULT;
			thr_r <= PFE_RST_THR;
			wait_r <= PFE_RST_WAIT;
			bc_r <= PFE_RST_BC;
			leg_r <= PFE_RST_LEG;
			reg_rdata_r <= 8'h00;
		end
		else
		begin
			fault_r <= fault_nxt;
			thr_r <= thr_nxt;
			wait_r <= wait_nxt;
			bc_r <= bc_nxt;
			leg_r <= leg_nxt;
			reg_rdata_r <= rdata_nxt;
		end
	end

	// One timer serves both the retry delay and the test period, which never overlap.
	pfe_state_t st_r, st_nxt;
	logic ft_start, ft_done, th_start, th_busy, rw_start, rw_busy;
	logic [11:0] ft_load, th_load, rw_load;
	logic err_nxt, tcur_nxt, sw_nxt, short_nxt, treg_d_r;

	// Fault recovery sequencing.
	always_comb
	begin
		st_nxt = st_r;
		ft_start = 1'b0;
		ft_load = retry_ms(retry_sel);
		short_nxt = 1'b0;
		unique case (st_r)
			PFE_ST_RUN:
				if (fault_detect)
				begin
					st_nxt = PFE_ST_ERROR;
					ft_start = !latch_on_error;
				end
			PFE_ST_ERROR:
				if (latch_on_error)
				begin
					if (err_clear)
						st_nxt = PFE_ST_RUN;
				end
				else if (ft_done)
					st_nxt = PFE_ST_CHECK;
			PFE_ST_CHECK:
				if (checks_ok)
				begin
					st_nxt = PFE_ST_TEST;
					ft_start = 1'b1;
					ft_load = test_ms(tper_sel);
				end
			PFE_ST_TEST:
				if (ft_done)
				begin
					if (vbus_mv < vtest_mv(vtst_sel))
					begin
						st_nxt = PFE_ST_ERROR;
						short_nxt = 1'b1;
						ft_start = !latch_on_error;
					end
					else
						st_nxt = PFE_ST_RUN;
				end
		endcase
		err_nxt = (st_nxt != PFE_ST_RUN);
		tcur_nxt = (st_nxt == PFE_ST_TEST);
		sw_nxt = (st_nxt == PFE_ST_RUN) || (st_nxt == PFE_ST_TEST);
	end

	// Recovery state flops.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_r <= PFE_ST_RUN;
			error_flag_r <= 1'b0;
			test_current_r <= 1'b0;
			switch_on_r <= 1'b1;
			short_found_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			error_flag_r <= err_nxt;
			test_current_r <= tcur_nxt;
			switch_on_r <= sw_nxt;
			short_found_r <= short_nxt;
		end
	end

	pfe_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_fault_tmr
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.start(ft_start),
		.load_ms(ft_load),
		.busy(),
		.done(ft_done)
	);

	// Thermal hold restarts on each rise above the regulation threshold.
	assign th_start = over_treg && !treg_d_r;
	assign th_load = PFE_THOLD_BASE_MS << thold_sel;
	pfe_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_thermal_tmr
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.start(th_start),
		.load_ms(th_load),
		.busy(th_busy),
		.done()
	);

	// Recharge wait gives the bus capacitor time before attach detection resumes.
	assign rw_start = bypass_reactivated;
	assign rw_load = (rwait_sel == 3'h7) ? PFE_RWAIT_TOP_MS
		: PFE_RWAIT_STEP_MS * ({9'h000, rwait_sel} + 12'h001);
	pfe_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_recharge_tmr
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.start(rw_start),
		.load_ms(rw_load),
		.busy(rw_busy),
		.done()
	);

	// Status outputs; the hold flags also cover the start cycle so no gap opens.
	logic emu_nxt, current_limit_value_nxt, att_nxt, dcp_nxt;
	logic [6:0] leg_en_nxt;
	always_comb
	begin
		emu_nxt = ibus_10ua > (PFE_CHG_LSB_10UA * {15'h0000, charge_detect_level});
		current_limit_value_nxt = !(th_busy || th_start);
		att_nxt = !(rw_busy || rw_start);
		dcp_nxt = !bc_r[PFE_DCP_OFF_BIT] || dcp_mode(mode_select_a, mode_select_b, emulation_on);
		leg_en_nxt = '0;
		for (int i = 0; i < 7; i++)
			leg_en_nxt[i] = !leg_r[i];
	end

	// Status output flops.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			treg_d_r <= 1'b0;
			emulation_ok_r <= 1'b0;
			current_limit_value_change_ok_r <= 1'b1;
			attach_ok_r <= 1'b1;
			dcp_profile_en_r <= 1'b0;
			legacy_profile_en_r <= 7'h7F;
		end
		else
		begin
			treg_d_r <= over_treg;
			emulation_ok_r <= emu_nxt;
			current_limit_value_change_ok_r <= current_limit_value_nxt;
			attach_ok_r <= att_nxt;
			dcp_profile_en_r <= dcp_nxt;
			legacy_profile_en_r <= leg_en_nxt;
		end
	end

	// Checks on the recovery sequence and the configuration effects.
	sequence s_test_go;
		st_r == PFE_ST_CHECK && checks_ok;
	endsequence
	sequence s_short;
		st_r == PFE_ST_TEST && ft_done && vbus_mv < vtest_mv(vtst_sel);
	endsequence
	property p_test_start;
		@(posedge mclk) disable iff (!reset_n) s_test_go |=> test_current_r && switch_on_r && st_r == PFE_ST_TEST;
	endproperty
	a_test_start: assert property (p_test_start) else $error("Test phase not entered.");
	property p_short;
		@(posedge mclk) disable iff (!reset_n) s_short |=> st_r == PFE_ST_ERROR && short_found_r && !switch_on_r;
	endproperty
	a_short: assert property (p_short) else $error("Short not returned to error.");
	property p_retry_len;
		@(posedge mclk) disable iff (!reset_n)
			st_r == PFE_ST_RUN && ft_start |-> ft_load == 12'd15 + 12'd5 * {9'h000, retry_sel};
	endproperty
	a_retry_len: assert property (p_retry_len) else $error("Retry delay length wrong.");
	property p_test_len;
		@(posedge mclk) disable iff (!reset_n) s_test_go |-> ft_load == 12'd10 + 12'd5 * {10'h000, tper_sel};
	endproperty
	a_test_len: assert property (p_test_len) else $error("Test period length wrong.");
	property p_emu;
		@(posedge mclk) disable iff (!reset_n)
			ibus_10ua > 19'd1172 * {15'h0000, thr_r[3:0]} |=> emulation_ok_r;
	endproperty
	a_emu: assert property (p_emu) else $error("Emulation success missed.");
	property p_sleep;
		@(posedge mclk) disable iff (!reset_n) sleep_entry |=> thr_r == 8'h0F && fault_r == $past(fault_nxt);
	endproperty
	a_sleep: assert property (p_sleep) else $error("Sleep threshold restore wrong.");
	property p_thermal;
		@(posedge mclk) disable iff (!reset_n) $rose(over_treg) |=> !current_limit_value_change_ok_r ##1 !current_limit_value_change_ok_r[*3];
	endproperty
	a_thermal: assert property (p_thermal) else $error("Thermal hold not applied.");
	property p_recharge;
		@(posedge mclk) disable iff (!reset_n) bypass_reactivated |=> !attach_ok_r[*4];
	endproperty
	a_recharge: assert property (p_recharge) else $error("Attach not held off.");
	property p_dcp;
		@(posedge mclk) disable iff (!reset_n)
			bc_r[4] && !(mode_select_a && mode_select_b && emulation_on) |=> !dcp_profile_en_r;
	endproperty
	a_dcp: assert property (p_dcp) else $error("DCP profile not excluded.");
	property p_legacy;
		@(posedge mclk) disable iff (!reset_n) ##1 legacy_profile_en_r == ~$past(leg_r[6:0]);
	endproperty
	a_legacy: assert property (p_legacy) else $error("Legacy enables wrong.");
	property p_latch;
		@(posedge mclk) disable iff (!reset_n)
			st_r == PFE_ST_ERROR && latch_on_error && !err_clear |=> st_r == PFE_ST_ERROR;
	endproperty
	a_latch: assert property (p_latch) else $error("Latched error left early.");
endmodule
`default_nettype wire

/* verification/pfe_device_model.sv */
// Behavioural model of the portable device and bus load seen on the port.
`default_nettype none
module pfe_device_model
(
	input wire logic switch_on, // Port power switch state.
	input wire logic shorted, // Scenario command: port is short-circuited.
	input wire logic [18:0] load_10ua, // Current the device draws when powered.
	output logic [12:0] vbus_mv, // Bus voltage seen by the block.
	output logic [18:0] ibus_10ua // Bus current seen by the block.
);
	timeunit 1ns;
	timeprecision 1ps;
	// An unpowered bus is discharged, so it reads 0 V rather than holding a stale level.
	assign vbus_mv = !switch_on ? 13'h0000 : (shorted ? 13'h0064 : 13'h1388);
	// Current only flows while the switch feeds the port.
	assign ibus_10ua = switch_on ? load_10ua : 19'h00000;
endmodule
`default_nettype wire

/* verification/pfe_port_cfg_test.sv */
// Self-checking testbench of the port configuration and fault timing block.
`default_nettype none
module pfe_port_cfg_test;
	import pfe_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPM = 10; // Shortened millisecond so long timers fit the run.
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	pfe_req_t reg_req = '0;
	logic [7:0] reg_rdata_r;
	logic sleep_entry = 1'b0, fault_detect = 1'b0, latch_on_error = 1'b0, err_clear = 1'b0;
	logic checks_ok = 1'b0, over_treg = 1'b0, bypass_reactivated = 1'b0, shorted = 1'b0;
	logic mode_select_a = 1'b0, mode_select_b = 1'b0, emulation_on = 1'b0;
	logic [18:0] load_10ua = 19'h00000;
	logic [12:0] vbus_mv;
	logic [18:0] ibus_10ua;
	logic error_flag_r, test_current_r, switch_on_r, short_found_r, emulation_ok_r;
	logic current_limit_value_change_ok_r, attach_ok_r, dcp_profile_en_r;
	logic [6:0] legacy_profile_en_r;
	int n_fail = 0;
	int checks = 0;
	int n;
	logic [7:0] ofs[5] = '{PFE_OFS_FAULT, PFE_OFS_THR, PFE_OFS_WAIT, PFE_OFS_BC, PFE_OFS_LEG};
	logic [7:0] rst[5] = '{PFE_RST_FAULT, PFE_RST_THR, PFE_RST_WAIT, PFE_RST_BC, PFE_RST_LEG};
	logic [7:0] msk[5] = '{PFE_MSK_FAULT, PFE_MSK_THR, PFE_MSK_WAIT, PFE_MSK_BC, PFE_MSK_LEG};
	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;
	pfe_port_cfg #(.CYCLES_PER_MS(CPM)) pfe_port_cfg_i (.mclk(mclk), .reset_n(reset_n), .reg_req(reg_req),
		.reg_rdata_r(reg_rdata_r), .sleep_entry(sleep_entry), .fault_detect(fault_detect),
		.latch_on_error(latch_on_error), .err_clear(err_clear), .checks_ok(checks_ok), .vbus_mv(vbus_mv),
		.ibus_10ua(ibus_10ua), .over_treg(over_treg), .bypass_reactivated(bypass_reactivated),
		.mode_select_a(mode_select_a), .mode_select_b(mode_select_b), .emulation_on(emulation_on),
		.error_flag_r(error_flag_r), .test_current_r(test_current_r), .switch_on_r(switch_on_r),
		.short_found_r(short_found_r), .emulation_ok_r(emulation_ok_r), .current_limit_value_change_ok_r(current_limit_value_change_ok_r),
		.attach_ok_r(attach_ok_r), .dcp_profile_en_r(dcp_profile_en_r), .legacy_profile_en_r(legacy_profile_en_r));
	pfe_device_model pfe_device_model_i (.switch_on(switch_on_r), .shorted(shorted), .load_10ua(load_10ua),
		.vbus_mv(vbus_mv), .ibus_10ua(ibus_10ua));
	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Compares a value with four-state equality so an unknown never matches.
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Checks that a measured cycle count lies inside a window.
	task automatic chk_rng(input string nm, input int v, input int lo, input int hi);
		checks++;
		if (v < lo || v > hi)
		begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask
	// Selects one output flag by number for the waiting task.
	function automatic logic sig(input int k);
		case (k)
			0: return test_current_r;
			1: return current_limit_value_change_ok_r;
			2: return attach_ok_r;
			default: return error_flag_r;
		endcase
	endfunction
	// Counts falling edges until a flag takes a level; running out of the bound ends the run.
	task automatic wt(input int k, input logic v, input int lim, output int c);
		c = 0;
		while (sig(k) !== v && c < lim)
		begin
			@(negedge mclk);
			c++;
		end
		// The level is tested again here so that a flag reached on the last allowed edge is not counted as a timeout.
		if (sig(k) !== v)
		begin
			n_fail++;
			$display("[ERR] wait on flag %0d expected %b seen timeout", k, v);
			tally_and_finish();
		end
	endtask
	// One-cycle write strobe on the register port, then one idle cycle.
	// The idle cycle keeps a following call from driving the request twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk);
		reg_req = '0;
		@(negedge mclk);
	endtask
	// One-cycle read strobe; data is valid the cycle after the strobe is taken.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk);
		reg_req = '0;
		chk("reg_rdata_r", e, reg_rdata_r);
		@(negedge mclk);
	endtask
	// Raises a one-cycle pulse on a control input chosen by number.
	task automatic pulse(input int k);
		case (k)
			0: fault_detect = 1'b1;
			1: err_clear = 1'b1;
			2: sleep_entry = 1'b1;
			default: bypass_reactivated = 1'b1;
		endcase
		@(negedge mclk);
		{fault_detect, err_clear, sleep_entry, bypass_reactivated} = 4'h0;
	endtask
	// Cuts a hang short.
	initial
	begin
		repeat (100000) @(posedge mclk);
		n_fail++;
		$display("[ERR] run length expected finish seen timeout");
		tally_and_finish();
	end
	// Main sequence.
	initial
	begin
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		repeat (2) @(negedge mclk);
		for (int i = 0; i < 5; i++)
			rd_chk(ofs[i], rst[i]);
		rd_chk(8'h1D, 8'h00);
		chk("legacy_profile_en_r", 8'h7F, {1'b0, legacy_profile_en_r});
		chk("dcp_profile_en_r", 8'h00, {7'h00, dcp_profile_en_r});
		for (int i = 0; i < 5; i++)
		begin
			wr(ofs[i], 8'hFF);
			rd_chk(ofs[i], msk[i]);
		end
		wr(8'h25, 8'hFF);
		rd_chk(8'h25, 8'h00);
		// Each legacy off bit must clear only its own profile.
		for (int i = 0; i < 7; i++)
		begin
			wr(PFE_OFS_LEG, 8'h01 << i);
			repeat (2) @(negedge mclk);
			chk("legacy_profile_en_r", ~(8'h81 << i) & 8'h7F | 8'h00, {1'b0, legacy_profile_en_r});
		end
		// The off bit is set now; DCP mode must override it, and clearing it enables the profile.
		{mode_select_a, mode_select_b, emulation_on} = 3'b111;
		repeat (2) @(negedge mclk);
		chk("dcp_profile_en_r", 8'h01, {7'h00, dcp_profile_en_r});
		{mode_select_a, mode_select_b, emulation_on} = 3'b110;
		repeat (2) @(negedge mclk);
		chk("dcp_profile_en_r", 8'h00, {7'h00, dcp_profile_en_r});
		wr(PFE_OFS_BC, 8'h07);
		repeat (2) @(negedge mclk);
		chk("dcp_profile_en_r", 8'h01, {7'h00, dcp_profile_en_r});
		// Emulation succeeds only strictly above two counts of threshold.
		wr(PFE_OFS_THR, 8'h02);
		load_10ua = 19'd2344;
		repeat (3) @(negedge mclk);
		chk("emulation_ok_r", 8'h00, {7'h00, emulation_ok_r});
		load_10ua = 19'd2345;
		repeat (3) @(negedge mclk);
		chk("emulation_ok_r", 8'h01, {7'h00, emulation_ok_r});
		pulse(2);
		rd_chk(PFE_OFS_THR, PFE_RST_THR);
		rd_chk(PFE_OFS_BC, 8'h07);
		// Retry code 100 with 10 ms test and 500 mV decision level; first attempt sees a short.
		wr(PFE_OFS_FAULT, 8'h41);
		checks_ok = 1'b1;
		shorted = 1'b1;
		pulse(0);
		wt(0, 1'b1, 1000, n);
		chk_rng("retry delay", n, 348, 356);
		chk("switch_on_r", 8'h01, {7'h00, switch_on_r});
		wt(0, 1'b0, 1000, n);
		chk_rng("test period", n, 98, 104);
		chk("short_found_r", 8'h01, {7'h00, short_found_r});
		chk("error_flag_r", 8'h01, {7'h00, error_flag_r});
		shorted = 1'b0;
		wt(0, 1'b1, 1000, n);
		wt(0, 1'b0, 1000, n);
		repeat (2) @(negedge mclk);
		chk("error_flag_r", 8'h00, {7'h00, error_flag_r});
		chk("switch_on_r", 8'h01, {7'h00, switch_on_r});
		// With latching on, no retry happens until software clears the flag.
		latch_on_error = 1'b1;
		pulse(0);
		repeat (600) @(negedge mclk);
		chk("error_flag_r", 8'h01, {7'h00, error_flag_r});
		chk("test_current_r", 8'h00, {7'h00, test_current_r});
		pulse(1);
		repeat (3) @(negedge mclk);
		chk("error_flag_r", 8'h00, {7'h00, error_flag_r});
		// Shortest hold and wait codes: 200 ms each.
		wr(PFE_OFS_WAIT, 8'h00);
		over_treg = 1'b1;
		wt(1, 1'b0, 5, n);
		wt(1, 1'b1, 3000, n);
		chk_rng("thermal hold", n, 1997, 2004);
		pulse(3);
		wt(2, 1'b0, 5, n);
		wt(2, 1'b1, 3000, n);
		chk_rng("recharge wait", n, 1997, 2004);
		// A wait above 800 ms suits a large bus capacitance: code 100 gives 1000 ms.
		wr(PFE_OFS_WAIT, 8'h04);
		pulse(3);
		wt(2, 1'b0, 5, n);
		wt(2, 1'b1, 12000, n);
		chk_rng("long recharge wait", n, 9997, 10004);
		tally_and_finish();
	end
endmodule
`default_nettype wire
